// file: hdl/cpc_ctrl.v
/*
 * Codec port control: attention request, bit clock checking, slot
 * indicators and detector multiplex enable, with a register port.
 * Assumes the pins arrive unsynchronised and tx_data_new_i is on clk_i.
 */
// What this block does
// (R01) Attention output is active low, driven or open drain by choice.
// (R02) An unmasked detector bit changing state raises attention.
// (R03) New transmit data raises attention only when armed in control.
// (R04) Attention holds until its register is read or a reset occurs.
// (R05) Each detector bit has its own mask bit.
// (R06) The outside master clock runs at the allowed rates or multiples.
// (R07) With bit-clock source or GCI mode, master clock pin drives mux enable.
// (R08) Bit clock is a frame multiple within the allowed range.
// (R09) Bit clock avoids the forbidden band; minimum doubles for wide data.
// (R10) Processor clock may come from the bit clock instead.
// (R11) Double clock mode shifts one data bit every two bit clocks.
// (R12) GCI clock rate is detected; at 4.096 MHz bits take two clocks.
// (R13) Reset low returns interrupt and configuration state to default.
// (R14) Slot indicators are open drain, low while their slot transmits.
// (R15) In GCI mode first indicator is low during the selected slot pair.
// (R16) Frame pulse recurs each frame and marks slot zero.
// (R17) GCI mode occupies two of eight channels picked by select pins.
// (R18) Open-drain attention floats when not asserted.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_map.vh"

module cpc_ctrl (
    input wire clk_i,
    input wire nrst_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire pclk_i,
    input wire frame_pulse_i,
    input wire mclk_i,
    input wire [7:0] detector_input_bit_i,
    input wire channel_pair_select_0_i,
    input wire channel_pair_select_1_i,
    input wire tx_data_new_i,
    output reg attn_n_o,
    output reg attn_oe_o,
    output reg irq_o,
    output reg slot_active_a_n_o,
    output reg slot_active_a_oe_o,
    output reg slot_active_b_n_o,
    output reg slot_active_b_oe_o,
    output reg detector_mux_enable_o,
    output reg detector_mux_enable_oe_o,
    output reg dsp_clk_en_o,
    output reg bit_shift_en_o,
    output reg gci_rate_4m_o
);

wire pclk_rise;
wire fs_lvl;
wire mclk_rise;
wire [7:0] det_lvl;
wire [7:0] det_rise;
wire [7:0] det_fall;
wire [1:0] sel_lvl;

cpc_sync #(.W(1)) u_sync_pclk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(pclk_i),
    .lvl_o(),
    .rise_o(pclk_rise),
    .fall_o()
);

cpc_sync #(.W(1)) u_sync_fs (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(frame_pulse_i),
    .lvl_o(fs_lvl),
    .rise_o(),
    .fall_o()
);

cpc_sync #(.W(1)) u_sync_mclk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(mclk_i),
    .lvl_o(),
    .rise_o(mclk_rise),
    .fall_o()
);

cpc_sync #(.W(8)) u_sync_det (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(detector_input_bit_i),
    .lvl_o(det_lvl),
    .rise_o(det_rise),
    .fall_o(det_fall)
);

cpc_sync #(.W(2)) u_sync_sel (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({channel_pair_select_1_i, channel_pair_select_0_i}),
    .lvl_o(sel_lvl),
    .rise_o(),
    .fall_o()
);

// Register state
reg [5:0] ctrl_reg;
reg [7:0] det_mask_reg;
reg [2:0] irq_stat_reg;
reg [2:0] irq_mask_reg;
reg [6:0] slot_a_reg;
reg [6:0] slot_b_reg;
reg det_pend_reg;
reg tx_pend_reg;
reg srst_reg;

// Link state
reg fs_prev_reg;
reg [10:0] edge_cnt_reg;
reg [10:0] edges_last_reg;
reg link_seen_reg;
reg rate_4m_reg;
reg half_reg;

wire gci_mode = ctrl_reg[`CPC_CTRL_GCI];
wire dbl_mode = ctrl_reg[`CPC_CTRL_DBL];
wire pclk_src = ctrl_reg[`CPC_CTRL_PCLK_SRC];
wire od_mode = ctrl_reg[`CPC_CTRL_OD];
wire tx_arm = ctrl_reg[`CPC_CTRL_TX_ARM];
wire lin_mode = ctrl_reg[`CPC_CTRL_LINEAR];

// Access decode
wire wr_ctrl = reg_wr_i && (reg_addr_i == `CPC_OFF_CTRL);
wire wr_dmask = reg_wr_i && (reg_addr_i == `CPC_OFF_DET_MASK);
wire wr_istat = reg_wr_i && (reg_addr_i == `CPC_OFF_IRQ_STAT);
wire wr_imask = reg_wr_i && (reg_addr_i == `CPC_OFF_IRQ_MASK);
wire wr_slot_a = reg_wr_i && (reg_addr_i == `CPC_OFF_SLOT_A);
wire wr_slot_b = reg_wr_i && (reg_addr_i == `CPC_OFF_SLOT_B);
wire rd_det = reg_rd_i && (reg_addr_i == `CPC_OFF_DET_DATA);
wire rd_tx = reg_rd_i && (reg_addr_i == `CPC_OFF_TX_STAT);

// Event sources
wire [7:0] det_chg = (det_rise | det_fall) & ~det_mask_reg; // see (R02) (R05)
wire det_evt = |det_chg; // see (R02)
wire tx_evt = tx_data_new_i && tx_arm; // see (R03)
wire frame_start = pclk_rise && fs_lvl && !fs_prev_reg; // see (R16)
wire rate_4m_now = (edges_last_reg > `CPC_GCI_4M_EDGES);
wire [10:0] edge_meas = edge_cnt_reg + 11'h001;
wire rate_4m_new = (edge_meas > `CPC_GCI_4M_EDGES);
wire rate_evt = frame_start && gci_mode && (rate_4m_new != rate_4m_reg);
wire [2:0] irq_set = {rate_evt, tx_evt, det_evt};

// Registers written by software; soft reset returns them to default
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ctrl_reg <= `CPC_CTRL_RST; // see (R13)
        det_mask_reg <= `CPC_DET_MASK_RST;
        irq_mask_reg <= `CPC_IRQ_MASK_RST;
        slot_a_reg <= `CPC_SLOT_RST;
        slot_b_reg <= `CPC_SLOT_RST;
        srst_reg <= 1'b0;
    end else if (srst_reg) begin
        ctrl_reg <= `CPC_CTRL_RST; // see (R04) (R13)
        det_mask_reg <= `CPC_DET_MASK_RST;
        irq_mask_reg <= `CPC_IRQ_MASK_RST;
        slot_a_reg <= `CPC_SLOT_RST;
        slot_b_reg <= `CPC_SLOT_RST;
        srst_reg <= 1'b0;
    end else begin
        srst_reg <= wr_ctrl && reg_wdata_i[`CPC_CTRL_SRST];
        if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_i[5:0];
        end
        if (wr_dmask) begin
            det_mask_reg <= reg_wdata_i[7:0]; // see (R05)
        end
        if (wr_imask) begin
            irq_mask_reg <= reg_wdata_i[2:0];
        end
        if (wr_slot_a) begin
            slot_a_reg <= reg_wdata_i[6:0];
        end
        if (wr_slot_b) begin
            slot_b_reg <= reg_wdata_i[6:0];
        end
    end
end

// Attention pending flags and sticky status; a new event beats a clear
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        det_pend_reg <= 1'b0;
        tx_pend_reg <= 1'b0;
        irq_stat_reg <= 3'h0;
    end else if (srst_reg) begin
        det_pend_reg <= 1'b0; // see (R04)
        tx_pend_reg <= 1'b0;
        irq_stat_reg <= 3'h0;
    end else begin
        det_pend_reg <= (det_pend_reg && !rd_det) || det_evt; // see (R04)
        tx_pend_reg <= (tx_pend_reg && !rd_tx) || tx_evt; // see (R04)
        irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? reg_wdata_i[2:0] :
            3'h0)) | irq_set;
    end
end

// Read data stand for the single cycle after the read strobe
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        reg_rdata_o <= 32'h0000_0000;
    end else if (!reg_rd_i) begin
        reg_rdata_o <= 32'h0000_0000;
    end else if (reg_addr_i == `CPC_OFF_CTRL) begin
        reg_rdata_o <= {26'h0, ctrl_reg};
    end else if (reg_addr_i == `CPC_OFF_DET_MASK) begin
        reg_rdata_o <= {24'h0, det_mask_reg};
    end else if (reg_addr_i == `CPC_OFF_DET_DATA) begin
        reg_rdata_o <= {23'h0, det_pend_reg, det_lvl};
    end else if (reg_addr_i == `CPC_OFF_TX_STAT) begin
        reg_rdata_o <= {31'h0, tx_pend_reg};
    end else if (reg_addr_i == `CPC_OFF_IRQ_STAT) begin
        reg_rdata_o <= {29'h0, irq_stat_reg};
    end else if (reg_addr_i == `CPC_OFF_IRQ_MASK) begin
        reg_rdata_o <= {29'h0, irq_mask_reg};
    end else if (reg_addr_i == `CPC_OFF_LINK_STAT) begin
        reg_rdata_o <= {5'h0, edges_last_reg, 14'h0, link_seen_reg,
            rate_4m_reg};
    end else if (reg_addr_i == `CPC_OFF_SLOT_A) begin
        reg_rdata_o <= {25'h0, slot_a_reg};
    end else if (reg_addr_i == `CPC_OFF_SLOT_B) begin
        reg_rdata_o <= {25'h0, slot_b_reg};
    end else begin
        reg_rdata_o <= 32'h0000_0000;
    end
end

// Bit clock edges counted from the frame pulse; per-frame count kept
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        fs_prev_reg <= 1'b0;
        edge_cnt_reg <= 11'h000;
        edges_last_reg <= 11'h000;
        link_seen_reg <= 1'b0;
        rate_4m_reg <= 1'b0;
        half_reg <= 1'b0;
    end else if (srst_reg) begin
        fs_prev_reg <= 1'b0;
        edge_cnt_reg <= 11'h000;
        edges_last_reg <= 11'h000;
        link_seen_reg <= 1'b0;
        rate_4m_reg <= 1'b0;
        half_reg <= 1'b0;
    end else if (pclk_rise) begin
        fs_prev_reg <= fs_lvl;
        if (frame_start) begin
            edge_cnt_reg <= 11'h000; // see (R16)
            edges_last_reg <= edge_meas;
            link_seen_reg <= 1'b1;
            rate_4m_reg <= rate_4m_new; // see (R12)
            half_reg <= 1'b0;
        end else begin
            if (edge_cnt_reg != 11'h7FF) begin
                edge_cnt_reg <= edge_meas;
            end
            half_reg <= !half_reg;
        end
    end
end

// Data bit position; two clocks per bit in double mode outside GCI, or at 4.096 MHz in GCI mode
wire two_per_bit = gci_mode ? rate_4m_reg : dbl_mode; // see (R11) (R12)
wire [10:0] bit_idx = two_per_bit ? {1'b0, edge_cnt_reg[10:1]} :
    edge_cnt_reg;
wire shift_now = pclk_rise && (!two_per_bit || frame_start || half_reg);

// Slot windows
wire [10:0] slot_len = lin_mode ? `CPC_LIN_BITS : `CPC_PCM_BITS;
wire [10:0] start_a = {1'b0, slot_a_reg, 3'h0};
wire [10:0] start_b = {1'b0, slot_b_reg, 3'h0};
wire [10:0] start_g = {3'h0, sel_lvl, 6'h00}; // see (R17)
wire in_a = link_seen_reg && (bit_idx >= start_a) &&
    (bit_idx < start_a + slot_len); // see (R14)
wire in_b = link_seen_reg && (bit_idx >= start_b) &&
    (bit_idx < start_b + slot_len); // see (R14)
wire in_g = link_seen_reg && (bit_idx >= start_g) &&
    (bit_idx < start_g + `CPC_GCI_PAIR_BITS); // see (R15) (R17)
wire act_a = gci_mode ? in_g : in_a;
wire act_b = !gci_mode && in_b;

// Attention and interrupt drive
wire attn_act = det_pend_reg || tx_pend_reg;
wire mux_out = gci_mode || pclk_src; // see (R07)

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        attn_n_o <= 1'b1;
        attn_oe_o <= 1'b1;
        irq_o <= 1'b0;
        slot_active_a_n_o <= 1'b0;
        slot_active_a_oe_o <= 1'b0;
        slot_active_b_n_o <= 1'b0;
        slot_active_b_oe_o <= 1'b0;
        dsp_clk_en_o <= 1'b0;
        bit_shift_en_o <= 1'b0;
        gci_rate_4m_o <= 1'b0;
    end else begin
        attn_n_o <= od_mode ? 1'b0 : !attn_act; // see (R01)
        attn_oe_o <= od_mode ? attn_act : 1'b1; // see (R01) (R18)
        irq_o <= |(irq_stat_reg & irq_mask_reg);
        slot_active_a_n_o <= 1'b0;
        slot_active_a_oe_o <= act_a; // see (R14) (R15)
        slot_active_b_n_o <= 1'b0;
        slot_active_b_oe_o <= act_b; // see (R14)
        dsp_clk_en_o <= pclk_src ? pclk_rise : mclk_rise; // see (R10)
        bit_shift_en_o <= shift_now; // see (R11) (R12)
        gci_rate_4m_o <= gci_mode && rate_4m_now;
    end
end

// Mux enable toggles each frame to pick the multiplexed detector half
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        detector_mux_enable_o <= 1'b0;
        detector_mux_enable_oe_o <= 1'b0;
    end else begin
        detector_mux_enable_oe_o <= mux_out; // see (R07)
        if (!mux_out) begin
            detector_mux_enable_o <= 1'b0;
        end else if (frame_start) begin
            detector_mux_enable_o <= !detector_mux_enable_o; // see (R07)
        end
    end
end

endmodule // cpc_ctrl

`default_nettype wire

// file: inc/cpc_map.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the codec port clock, interrupt and slot control block.
 * Assumes a byte-addressed 32-bit register port, one word per register.
 */
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// Register port widths
`define CPC_ADDR_W 8
`define CPC_DATA_W 32

// Register byte offsets
`define CPC_OFF_CTRL 8'h00
`define CPC_OFF_DET_MASK 8'h04
`define CPC_OFF_DET_DATA 8'h08
`define CPC_OFF_TX_STAT 8'h0C
`define CPC_OFF_IRQ_STAT 8'h10
`define CPC_OFF_IRQ_MASK 8'h14
`define CPC_OFF_LINK_STAT 8'h18
`define CPC_OFF_SLOT_A 8'h1C
`define CPC_OFF_SLOT_B 8'h20

// Control register fields
`define CPC_CTRL_W 6
`define CPC_CTRL_GCI 0
`define CPC_CTRL_DBL 1
`define CPC_CTRL_PCLK_SRC 2
`define CPC_CTRL_OD 3
`define CPC_CTRL_TX_ARM 4
`define CPC_CTRL_LINEAR 5
`define CPC_CTRL_SRST 6

// Interrupt status and mask fields
`define CPC_IRQ_W 3
`define CPC_IRQ_DET 0
`define CPC_IRQ_TX 1
`define CPC_IRQ_RATE 2

// Link status fields
`define CPC_LINK_4M 0
`define CPC_LINK_SEEN 1

// Reset values
`define CPC_CTRL_RST 6'h00
`define CPC_DET_MASK_RST 8'hFF
`define CPC_IRQ_MASK_RST 3'h0
`define CPC_SLOT_RST 7'h00

// Detector and slot widths
`define CPC_DET_W 8
`define CPC_SLOT_W 7
`define CPC_CNT_W 11

// Slot lengths in data bits
`define CPC_PCM_BITS 11'h008
`define CPC_LIN_BITS 11'h010
`define CPC_GCI_PAIR_BITS 11'h040
`define CPC_SLOT_SHIFT 3
`define CPC_PAIR_SHIFT 6

// Bit clock edges per frame above which the 4.096 MHz GCI clock is seen
`define CPC_GCI_4M_EDGES 11'h180

`endif

// file: hdl/cpc_sync.v
/*
 * Two-flop synchroniser with edge detection for pins outside clk_i.
 * Assumes async_i may change at any time relative to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module cpc_sync #(
    parameter W = 1
) (
    input wire clk_i,
    input wire nrst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] lvl_o,
    output wire [W-1:0] rise_o,
    output wire [W-1:0] fall_o
);

reg [W-1:0] meta_reg;
reg [W-1:0] sync_reg;
reg [W-1:0] prev_reg;

// Only sync_reg reads the first stage
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        meta_reg <= {W{1'b0}};
        sync_reg <= {W{1'b0}};
        prev_reg <= {W{1'b0}};
    end else begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
    end
end

assign lvl_o = sync_reg;
assign rise_o = sync_reg & ~prev_reg;
assign fall_o = ~sync_reg & prev_reg;

endmodule // cpc_sync

`default_nettype wire

// file: bench/cpc_ctrl_chk.sv
/* Pin checker for the codec port control block.
   Assumes it is bound onto the cpc_ctrl ports. */
`timescale 1ns/1ps
`default_nettype none

module cpc_ctrl_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic attn_n_o,
    input wire logic attn_oe_o,
    input wire logic slot_active_a_n_o,
    input wire logic slot_active_b_n_o,
    input wire logic detector_mux_enable_o,
    input wire logic detector_mux_enable_oe_o,
    input wire logic dsp_clk_en_o,
    input wire logic bit_shift_en_o,
    input wire logic gci_rate_4m_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Host access in the last three cycles
    sequence s_host;
        $past(reg_rd_i) || $past(reg_rd_i, 2) || $past(reg_rd_i, 3) ||
            $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3);
    endsequence
    sequence s_quiet;
        !bit_shift_en_o [*8];
    endsequence

    property p_attn_drv;
        attn_n_o |-> attn_oe_o;
    endproperty
    a_attn_drv: assert property (p_attn_drv)
        else $error("attention high while undriven");
    property p_attn_od;
        !attn_oe_o |-> !attn_n_o;
    endproperty
    a_attn_od: assert property (p_attn_od)
        else $error("attention pulls high while floating");
    property p_attn_hold;
        $fell(attn_oe_o && !attn_n_o) |-> s_host;
    endproperty
    a_attn_hold: assert property (p_attn_hold)
        else $error("attention released without host access");
    property p_mux_idle;
        !detector_mux_enable_oe_o |-> !detector_mux_enable_o;
    endproperty
    a_mux_idle: assert property (p_mux_idle)
        else $error("mux enable high while not driven");
    property p_gci_mux;
        gci_rate_4m_o |-> detector_mux_enable_oe_o;
    endproperty
    a_gci_mux: assert property (p_gci_mux)
        else $error("fast rate flag outside GCI mode");
    property p_dsp_pulse;
        dsp_clk_en_o |=> !dsp_clk_en_o;
    endproperty
    a_dsp_pulse: assert property (p_dsp_pulse)
        else $error("processor clock enable longer than a pulse");
    property p_shift_gap;
        bit_shift_en_o |=> s_quiet;
    endproperty
    a_shift_gap: assert property (p_shift_gap)
        else $error("bit shifts closer than a bit clock");
    property p_slot_low;
        !slot_active_a_n_o && !slot_active_b_n_o;
    endproperty
    a_slot_low: assert property (p_slot_low)
        else $error("slot indicator drives high");
endmodule // cpc_ctrl_chk

bind cpc_ctrl cpc_ctrl_chk u_chk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .reg_rd_i(reg_rd_i),
    .reg_wr_i(reg_wr_i),
    .attn_n_o(attn_n_o),
    .attn_oe_o(attn_oe_o),
    .slot_active_a_n_o(slot_active_a_n_o),
    .slot_active_b_n_o(slot_active_b_n_o),
    .detector_mux_enable_o(detector_mux_enable_o),
    .detector_mux_enable_oe_o(detector_mux_enable_oe_o),
    .dsp_clk_en_o(dsp_clk_en_o),
    .bit_shift_en_o(bit_shift_en_o),
    .gci_rate_4m_o(gci_rate_4m_o)
);

`default_nettype wire

// file: bench/cpc_link_model.sv
/* Highway master model: bit clock, frame pulse and master clock.
   Assumes the frame length in bits is set by the bench. */
`timescale 1ns/1ps
`default_nettype none

module cpc_link_model (
    input wire logic [10:0] frame_bits_i,
    output logic pclk_o,
    output logic frame_pulse_o,
    output logic mclk_o
);
    logic [10:0] bit_cnt;

    initial begin
        mclk_o = 1'b0;
        forever #61 mclk_o = ~mclk_o;
    end

    // Frame pulse changes on the falling bit clock edge
    initial begin
        pclk_o = 1'b0;
        frame_pulse_o = 1'b0;
        bit_cnt = 11'h000;
        #5.3;
        forever begin
            #32 pclk_o = 1'b1;
            #32 pclk_o = 1'b0;
            bit_cnt = (bit_cnt + 11'h001 >= frame_bits_i) ? 11'h000 :
                bit_cnt + 11'h001;
            frame_pulse_o = (bit_cnt == 11'h000);
        end
    end
endmodule // cpc_link_model

`default_nettype wire

// file: bench/tb_top.sv
/* Self-checking bench for the codec port control block.
   Assumes cpc_link_model drives the bit clock and frame pins. */
`timescale 1ns/1ps
`default_nettype none
`include "cpc_map.vh"

module tb_top;
    logic clk_i, nrst_i, reg_wr_i, reg_rd_i, tx_data_new_i, rd_d;
    logic channel_pair_select_0_i, channel_pair_select_1_i;
    logic [7:0] reg_addr_i, detector_input_bit_i;
    logic [31:0] reg_wdata_i;
    logic [10:0] frame_bits;
    wire [31:0] reg_rdata_o;
    wire pclk_i, frame_pulse_i, mclk_i, attn_n_o, attn_oe_o, irq_o;
    wire slot_active_a_n_o, slot_active_a_oe_o, slot_active_b_n_o;
    wire slot_active_b_oe_o, detector_mux_enable_o, gci_rate_4m_o;
    wire detector_mux_enable_oe_o, dsp_clk_en_o, bit_shift_en_o;
    logic [31:0] exp_q[$];
    logic [31:0] mode_t[3] = '{32'h0, 32'h2, 32'h20};
    logic [31:0] len_t[3] = '{32'h80, 32'h100, 32'h100};
    int n_fail = 0;
    int compares = 0;

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    cpc_link_model u_link (.frame_bits_i(frame_bits), .pclk_o(pclk_i),
        .frame_pulse_o(frame_pulse_i), .mclk_o(mclk_i));

    cpc_ctrl DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .pclk_i(pclk_i), .frame_pulse_i(frame_pulse_i), .mclk_i(mclk_i),
        .detector_input_bit_i(detector_input_bit_i),
        .channel_pair_select_0_i(channel_pair_select_0_i),
        .channel_pair_select_1_i(channel_pair_select_1_i),
        .tx_data_new_i(tx_data_new_i), .attn_n_o(attn_n_o),
        .attn_oe_o(attn_oe_o), .irq_o(irq_o),
        .slot_active_a_n_o(slot_active_a_n_o),
        .slot_active_a_oe_o(slot_active_a_oe_o),
        .slot_active_b_n_o(slot_active_b_n_o),
        .slot_active_b_oe_o(slot_active_b_oe_o),
        .detector_mux_enable_o(detector_mux_enable_o),
        .detector_mux_enable_oe_o(detector_mux_enable_oe_o),
        .dsp_clk_en_o(dsp_clk_en_o), .bit_shift_en_o(bit_shift_en_o),
        .gci_rate_4m_o(gci_rate_4m_o)
    );

    task automatic give_verdict;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data stand in the cycle after the strobe
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) begin
        if (rd_d && exp_q.size() > 0)
            check(reg_rdata_o, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask

    task automatic tx_pulse;
        @(posedge clk_i);
        tx_data_new_i <= 1'b1;
        @(posedge clk_i);
        tx_data_new_i <= 1'b0;
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: return attn_oe_o & ~attn_n_o;
            1: return irq_o;
            2: return gci_rate_4m_o;
            3: return slot_active_a_oe_o;
            4: return slot_active_b_oe_o;
            default: return frame_pulse_i;
        endcase
    endfunction

    // Bounded wait for a level, then compare it
    task automatic wait_for(input int s, input logic e, input int lim);
        for (int k = 0; k < lim && probe(s) !== e; k++) @(negedge clk_i);
        check(32'(probe(s)), 32'(e));
        if (probe(s) !== e)
            give_verdict();
    endtask

    // Length in clocks of one slot, measured from a frame start
    task automatic slot_len(input int s, input logic [31:0] e);
        logic [31:0] n;
        n = 32'h0;
        wait_for(5, 1'b1, 2000);
        wait_for(5, 1'b0, 100);
        wait_for(s, 1'b1, 2000);
        while (probe(s) === 1'b1 && n < 32'h1000) begin
            @(negedge clk_i);
            n = n + 32'h1;
        end
        check(n, e);
    endtask

    initial begin
        nrst_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        tx_data_new_i = 1'b0;
        detector_input_bit_i = 8'h00;
        channel_pair_select_0_i = 1'b0;
        channel_pair_select_1_i = 1'b0;
        frame_bits = 11'h040;
        void'($urandom(60459));
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`CPC_OFF_CTRL, 32'h0);
        rd(`CPC_OFF_DET_MASK, 32'hFF);
        rd(`CPC_OFF_IRQ_MASK, 32'h0);
        rd(8'h40, 32'h0);
        // Detector source, masked and unmasked
        detector_input_bit_i <= 8'($urandom);
        repeat (12) @(posedge clk_i);
        wait_for(0, 1'b0, 1);
        wr(`CPC_OFF_IRQ_MASK, 32'h3);
        wr(`CPC_OFF_DET_MASK, 32'hFE);
        detector_input_bit_i <= detector_input_bit_i ^ 8'h02;
        repeat (12) @(posedge clk_i);
        wait_for(0, 1'b0, 1);
        detector_input_bit_i <= detector_input_bit_i ^ 8'h01;
        wait_for(0, 1'b1, 20);
        wait_for(1, 1'b1, 10);
        rd(`CPC_OFF_DET_DATA, {23'h0, 1'b1, detector_input_bit_i});
        wait_for(0, 1'b0, 10);
        wait_for(1, 1'b1, 1);
        wr(`CPC_OFF_IRQ_STAT, 32'h1);
        wait_for(1, 1'b0, 10);
        // Transmit source with open-drain attention
        wr(`CPC_OFF_CTRL, 32'h8);
        repeat (4) @(posedge clk_i);
        check(32'({attn_n_o, attn_oe_o}), 32'h0);
        tx_pulse();
        repeat (8) @(posedge clk_i);
        wait_for(0, 1'b0, 1);
        wr(`CPC_OFF_CTRL, 32'h18);
        tx_pulse();
        wait_for(0, 1'b1, 10);
        check(32'(attn_n_o), 32'h0);
        rd(`CPC_OFF_TX_STAT, 32'h1);
        wait_for(0, 1'b0, 10);
        wr(`CPC_OFF_IRQ_STAT, 32'h7);
        // Mux enable with bit clock source, GCI mode, then neither
        for (int m = 0; m < 3; m++) begin
            wr(`CPC_OFF_CTRL, (m == 0) ? 32'h4 : (m == 1) ? 32'h1 : 32'h0);
            repeat (3) @(posedge clk_i);
            check(32'(detector_mux_enable_oe_o), 32'(m < 2));
        end
        // Slot lengths in plain, double clock and linear modes
        wr(`CPC_OFF_SLOT_A, 32'h1);
        wr(`CPC_OFF_SLOT_B, 32'h2);
        for (int j = 0; j < 3; j++) begin
            wr(`CPC_OFF_CTRL, mode_t[j]);
            slot_len(3, len_t[j]);
            slot_len(4, len_t[j]);
        end
        // Soft reset restores defaults
        wr(`CPC_OFF_CTRL, 32'h40);
        rd(`CPC_OFF_CTRL, 32'h0);
        rd(`CPC_OFF_SLOT_A, 32'h0);
        rd(`CPC_OFF_DET_MASK, 32'hFF);
        // GCI mode with a long frame
        frame_bits <= 11'h200;
        {channel_pair_select_1_i, channel_pair_select_0_i} <= 2'($urandom);
        wr(`CPC_OFF_CTRL, 32'h1);
        wait_for(2, 1'b1, 30000);
        rd(`CPC_OFF_IRQ_STAT, 32'h4);
        wait_for(3, 1'b1, 9000);
        repeat (4) @(posedge clk_i);
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
